/* File: core/ctrms_regs.vh */
// constants for the clock tree, reset pin and mode select block
`ifndef CTRMS_REGS_VH
`define CTRMS_REGS_VH
// reset pin drive length, in bus clock cycles
`define CTRMS_RST_DRIVE_BUS_CYC 7'h22
// guard after own drive ends, covers the pin synchroniser delay
`define CTRMS_RST_GUARD_CYC     3'h4
// debug clock cycles per bit time on the debug link
`define CTRMS_DBG_BIT_CYC       5'h10
// length of the high speedup pulse, in clk_sys cycles
`define CTRMS_SPEEDUP_CYC       2'h2
// reset cause bit positions
`define CTRMS_CAUSE_POR         0
`define CTRMS_CAUSE_LVD         1
`define CTRMS_CAUSE_WDOG        2
`define CTRMS_CAUSE_ILOP        3
`define CTRMS_CAUSE_ILAD        4
`define CTRMS_CAUSE_DBGF        5
`define CTRMS_CAUSE_PIN         6
`define CTRMS_CAUSE_W           8
// reset values
`define CTRMS_CAUSE_RST         8'h01
// external clock source indices in the sampled vector
`define CTRMS_SRC_SLOW          0
`define CTRMS_SRC_ERCLK         1
`define CTRMS_SRC_IRCLK         2
`define CTRMS_SRC_FFCLK         3
`define CTRMS_SRC_TMRA_PIN      4
`define CTRMS_SRC_TMRB_PIN      5
`define CTRMS_SRC_SPEEDUP       6
`define CTRMS_SRC_N             7
// real-time counter source codes
`define CTRMS_RTC_SLOW          2'h0
`define CTRMS_RTC_ERCLK         2'h1
`define CTRMS_RTC_IRCLK         2'h2
// timer source codes
`define CTRMS_TMR_BUS           2'h0
`define CTRMS_TMR_FFCLK         2'h1
`define CTRMS_TMR_PIN           2'h2
`endif

/* File: core/ctrms_core.v */
// clock tree enables, reset pin control and mode select capture
`timescale 1ns/10ps
`include "ctrms_regs.vh"
// Notes on behaviour
// - bus clock is primary clock-generator output divided by two
// - low-power 1 kHz clock selectable for watchdog and real-time counter
// - tools may pick the speedup clock as debug controller clock
// - external reference selectable for counter; alternate for converter and CAN
// - internal reference clock selectable as real-time counter source
// - fixed-frequency clock selectable as counting source of both timers
// - each timer may count its own external clock pin
// - after any reset the internally generated clock is in use
// - any reset drives the reset pin low about 34 bus cycles
// - reset cause is decoded and its status bit set
// - power-on and low-voltage detectors create resets internally
// - reset pin held low from outside puts the device in reset
// - pin selects mode during reset, carries debug link afterwards
// - undriven mode pin reads high, giving normal mode at release
// - mode pin low across reset release selects active background mode
// - a debug bit time lasts 16 debug controller clock cycles
// - debug controller clock may run at the bus clock rate
// - link drivers emit brief actively driven high speedup pulses
module ctrms_core #(
    parameter SRC_N = `CTRMS_SRC_N
) (
    input  wire                        clk_sys,
    input  wire                        rstn,
    input  wire                        low_power_1khz_clock,
    input  wire                        external_reference_clock,
    input  wire                        internal_reference_clock,
    input  wire                        fixed_frequency_clock,
    input  wire                        debug_speedup_clock,
    input  wire                        timer_a_external_clock_pin,
    input  wire                        timer_b_external_clock_pin,
    input  wire                        wdog_sel_slow,
    input  wire [1:0]                  rtc_sel,
    input  wire [1:0]                  timer_a_sel,
    input  wire [1:0]                  timer_b_sel,
    input  wire                        adc_sel_alt,
    input  wire                        can_sel_alt,
    input  wire                        dbg_sel_speedup,
    input  wire                        osc_sel_external,
    input  wire                        lvd_event,
    input  wire                        wdog_event,
    input  wire                        ilop_event,
    input  wire                        ilad_event,
    input  wire                        dbg_force_event,
    input  wire                        reset_pin_in,
    input  wire                        debug_mode_select_pin_in,
    input  wire                        dbg_tx_low,
    output reg                         bus_tick_q,
    output reg                         wdog_tick_q,
    output reg                         rtc_tick_q,
    output reg                         timer_a_tick_q,
    output reg                         timer_b_tick_q,
    output reg                         adc_alt_tick_q,
    output reg                         can_alt_tick_q,
    output reg                         dbg_tick_q,
    output reg                         dbg_bit_tick_q,
    output reg                         clk_internal_q,
    output reg                         reset_pin_out_q,
    output reg                         reset_pin_oe_q,
    output reg                         sys_reset_q,
    output reg [`CTRMS_CAUSE_W-1:0]    reset_cause_q,
    output reg                         bgnd_mode_q,
    output reg                         dbg_rx_q,
    output reg                         dms_out_q,
    output reg                         dms_oe_q
);

    // divider and source sampling
    reg                 div_q;
    wire [SRC_N-1:0]    src_raw;
    wire [SRC_N-1:0]    src_edge;

    assign src_raw = {debug_speedup_clock, timer_b_external_clock_pin,
                      timer_a_external_clock_pin, fixed_frequency_clock,
                      internal_reference_clock, external_reference_clock,
                      low_power_1khz_clock};

    // sources must stay below a quarter of clk_sys to be seen reliably
    genvar gi;
    generate
        for (gi = 0; gi < SRC_N; gi = gi + 1) begin : g_src
            reg s1_q;
            reg s2_q;
            reg s3_q;
            always @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                end else begin
                    s1_q <= src_raw[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                end
            end
            assign src_edge[gi] = s2_q & ~s3_q;
        end
    endgenerate

    // bus enable: one pulse every second clk_sys cycle
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            div_q <= 1'b0;
        end else begin
            div_q <= ~div_q;
        end
    end

    wire bus_en = div_q;

    // peripheral clock selection
    reg rtc_d;
    reg tmra_d;
    reg tmrb_d;
    always @* begin
        case (rtc_sel)
            `CTRMS_RTC_ERCLK: rtc_d = src_edge[`CTRMS_SRC_ERCLK];
            `CTRMS_RTC_IRCLK: rtc_d = src_edge[`CTRMS_SRC_IRCLK];
            default:          rtc_d = src_edge[`CTRMS_SRC_SLOW];
        endcase
        case (timer_a_sel)
            `CTRMS_TMR_FFCLK: tmra_d = src_edge[`CTRMS_SRC_FFCLK];
            `CTRMS_TMR_PIN:   tmra_d = src_edge[`CTRMS_SRC_TMRA_PIN];
            default:          tmra_d = bus_en;
        endcase
        case (timer_b_sel)
            `CTRMS_TMR_FFCLK: tmrb_d = src_edge[`CTRMS_SRC_FFCLK];
            `CTRMS_TMR_PIN:   tmrb_d = src_edge[`CTRMS_SRC_TMRB_PIN];
            default:          tmrb_d = bus_en;
        endcase
    end

    // debug clock: bus rate by default, speedup clock when tools ask
    wire dbg_en = dbg_sel_speedup ? src_edge[`CTRMS_SRC_SPEEDUP] : bus_en;

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bus_tick_q     <= 1'b0;
            wdog_tick_q    <= 1'b0;
            rtc_tick_q     <= 1'b0;
            timer_a_tick_q <= 1'b0;
            timer_b_tick_q <= 1'b0;
            adc_alt_tick_q <= 1'b0;
            can_alt_tick_q <= 1'b0;
            dbg_tick_q     <= 1'b0;
        end else begin
            bus_tick_q     <= bus_en;
            wdog_tick_q    <= wdog_sel_slow ? src_edge[`CTRMS_SRC_SLOW] : bus_en;
            rtc_tick_q     <= rtc_d;
            timer_a_tick_q <= tmra_d;
            timer_b_tick_q <= tmrb_d;
            adc_alt_tick_q <= adc_sel_alt ? src_edge[`CTRMS_SRC_ERCLK] : bus_en;
            can_alt_tick_q <= can_sel_alt ? src_edge[`CTRMS_SRC_ERCLK] : bus_en;
            dbg_tick_q     <= dbg_en;
        end
    end

    // debug bit timing
    reg [4:0] bit_cnt_q;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bit_cnt_q      <= 5'h00;
            dbg_bit_tick_q <= 1'b0;
        end else if (sys_reset_q) begin
            bit_cnt_q      <= 5'h00;
            dbg_bit_tick_q <= 1'b0;
        end else if (dbg_en) begin
            if (bit_cnt_q == `CTRMS_DBG_BIT_CYC - 5'h01) begin
                bit_cnt_q      <= 5'h00;
                dbg_bit_tick_q <= 1'b1;
            end else begin
                bit_cnt_q      <= bit_cnt_q + 5'h01;
                dbg_bit_tick_q <= 1'b0;
            end
        end else begin
            dbg_bit_tick_q <= 1'b0;
        end
    end

    // pin synchronisers
    reg rpin1_q;
    reg rpin2_q;
    reg dms1_q;
    reg dms2_q;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rpin1_q <= 1'b1;
            rpin2_q <= 1'b1;
            dms1_q  <= 1'b1;
            dms2_q  <= 1'b1;
        end else begin
            rpin1_q <= reset_pin_in;
            rpin2_q <= rpin1_q;
            dms1_q  <= debug_mode_select_pin_in;
            dms2_q  <= dms1_q;
        end
    end

    // reset pin drive and cause capture
    reg [6:0] drv_cnt_q;
    reg [2:0] guard_q;
    wire      int_evt = lvd_event | wdog_event | ilop_event | ilad_event
                      | dbg_force_event;
    // own drive reads back low, so the pin is trusted only after the guard
    wire      pin_evt = ~rpin2_q & ~reset_pin_oe_q & (guard_q == 3'h0);
    wire      driving = reset_pin_oe_q;

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            // power-on detector is the asynchronous reset itself
            drv_cnt_q      <= `CTRMS_RST_DRIVE_BUS_CYC;
            reset_pin_oe_q <= 1'b1;
            reset_pin_out_q <= 1'b0;
            guard_q        <= `CTRMS_RST_GUARD_CYC;
            reset_cause_q  <= `CTRMS_CAUSE_RST;
        end else begin
            reset_pin_out_q <= 1'b0;
            if (!driving && (int_evt || pin_evt)) begin
                drv_cnt_q      <= `CTRMS_RST_DRIVE_BUS_CYC;
                reset_pin_oe_q <= 1'b1;
                guard_q        <= `CTRMS_RST_GUARD_CYC;
                reset_cause_q  <= 8'h00;
                reset_cause_q[`CTRMS_CAUSE_LVD]  <= lvd_event;
                reset_cause_q[`CTRMS_CAUSE_WDOG] <= wdog_event;
                reset_cause_q[`CTRMS_CAUSE_ILOP] <= ilop_event;
                reset_cause_q[`CTRMS_CAUSE_ILAD] <= ilad_event;
                reset_cause_q[`CTRMS_CAUSE_DBGF] <= dbg_force_event;
                reset_cause_q[`CTRMS_CAUSE_PIN]  <= pin_evt & ~int_evt;
            end else if (driving) begin
                if (bus_en) begin
                    if (drv_cnt_q == 7'h01) begin
                        reset_pin_oe_q <= 1'b0;
                    end
                    drv_cnt_q <= drv_cnt_q - 7'h01;
                end
            end else if (guard_q != 3'h0) begin
                guard_q <= guard_q - 3'h1;
            end
        end
    end

    // system reset and mode capture
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sys_reset_q    <= 1'b1;
            bgnd_mode_q    <= 1'b0;
            clk_internal_q <= 1'b1;
        end else begin
            // held while driving, guarding or while the pin stays low outside
            sys_reset_q <= driving | (guard_q != 3'h0) | ~rpin2_q;
            if (sys_reset_q) begin
                clk_internal_q <= 1'b1;
            end else if (osc_sel_external) begin
                clk_internal_q <= 1'b0;
            end
            // one capture per release; later pin levels never touch the mode
            if (sys_reset_q && !(driving | (guard_q != 3'h0) | ~rpin2_q)) begin
                bgnd_mode_q <= ~dms2_q;
            end
        end
    end

    // debug link pin: pseudo open drain with speedup pulses
    reg       tx_low_prev_q;
    reg [1:0] spd_cnt_q;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_low_prev_q <= 1'b0;
            spd_cnt_q     <= 2'h0;
            dms_out_q     <= 1'b0;
            dms_oe_q      <= 1'b0;
            dbg_rx_q      <= 1'b1;
        end else if (sys_reset_q) begin
            // mode select input during reset: never driven
            tx_low_prev_q <= 1'b0;
            spd_cnt_q     <= 2'h0;
            dms_out_q     <= 1'b0;
            dms_oe_q      <= 1'b0;
            dbg_rx_q      <= 1'b1;
        end else begin
            tx_low_prev_q <= dbg_tx_low;
            dbg_rx_q      <= dms2_q;
            if (tx_low_prev_q && !dbg_tx_low) begin
                spd_cnt_q <= `CTRMS_SPEEDUP_CYC;
            end else if (spd_cnt_q != 2'h0) begin
                spd_cnt_q <= spd_cnt_q - 2'h1;
            end
            if (dbg_tx_low) begin
                dms_out_q <= 1'b0;
                dms_oe_q  <= 1'b1;
            end else if (tx_low_prev_q || spd_cnt_q > 2'h1) begin
                // short active high pulse, then release to the pull-up
                dms_out_q <= 1'b1;
                dms_oe_q  <= 1'b1;
            end else begin
                dms_out_q <= 1'b0;
                dms_oe_q  <= 1'b0;
            end
        end
    end

endmodule

/* File: test/ctrms_props.sv */
// property checker for the clock tree, reset pin and mode select block
`timescale 1ns/10ps
module ctrms_props (
    input wire       clk_sys,
    input wire       rstn,
    input wire       wdog_event,
    input wire       lvd_event,
    input wire       dbg_tx_low,
    input wire       bus_tick_q,
    input wire       clk_internal_q,
    input wire       reset_pin_out_q,
    input wire       reset_pin_oe_q,
    input wire       sys_reset_q,
    input wire [7:0] reset_cause_q,
    input wire       bgnd_mode_q,
    input wire       dms_out_q,
    input wire       dms_oe_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    reg [7:0] oe_cnt_q;
    // counts from release only, drive during rstn low is not part of the length
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) oe_cnt_q <= 8'h00;
        else oe_cnt_q <= reset_pin_oe_q ? oe_cnt_q + 8'h01 : 8'h00;
    end
    sequence s_bus_pair;
        !bus_tick_q ##1 bus_tick_q;
    endsequence
    sequence s_speedup;
        (dms_oe_q && dms_out_q) [*2] ##1 !dms_oe_q;
    endsequence
    property p_bus_div;
        bus_tick_q |=> s_bus_pair;
    endproperty
    property p_drive_len;
        $fell(reset_pin_oe_q) |-> oe_cnt_q inside {[66:69]};
    endproperty
    property p_wdog_rst;
        wdog_event && !reset_pin_oe_q |=> reset_pin_oe_q && reset_cause_q[2] ##1 sys_reset_q;
    endproperty
    property p_lvd_rst;
        lvd_event && !reset_pin_oe_q |=> reset_pin_oe_q && reset_cause_q[1];
    endproperty
    property p_int_clk;
        sys_reset_q [*3] |-> clk_internal_q;
    endproperty
    property p_mode_hold;
        !sys_reset_q && !$past(sys_reset_q) |-> $stable(bgnd_mode_q);
    endproperty
    property p_dbg_quiet;
        sys_reset_q |-> !dms_oe_q;
    endproperty
    property p_tx_low;
        dbg_tx_low && !sys_reset_q |=> sys_reset_q || (dms_oe_q && !dms_out_q);
    endproperty
    property p_speedup;
        dms_oe_q && !dms_out_q && !dbg_tx_low && !sys_reset_q |=> s_speedup;
    endproperty
    property p_pin_low;
        reset_pin_oe_q |-> !reset_pin_out_q;
    endproperty
    a_bus_div: assert property (p_bus_div) else $error("bus tick spacing wrong");
    a_drive_len: assert property (p_drive_len) else $error("pin drive length");
    a_wdog_rst: assert property (p_wdog_rst) else $error("watchdog reset");
    a_lvd_rst: assert property (p_lvd_rst) else $error("low voltage reset");
    a_int_clk: assert property (p_int_clk) else $error("clock not internal");
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed");
    a_dbg_quiet: assert property (p_dbg_quiet) else $error("pin driven in reset");
    a_tx_low: assert property (p_tx_low) else $error("pin not driven low");
    a_speedup: assert property (p_speedup) else $error("speedup pulse");
    a_pin_low: assert property (p_pin_low) else $error("reset pin driven high");
endmodule

bind ctrms_core ctrms_props u_props (
    .clk_sys         (clk_sys),
    .rstn            (rstn),
    .wdog_event      (wdog_event),
    .lvd_event       (lvd_event),
    .dbg_tx_low      (dbg_tx_low),
    .bus_tick_q      (bus_tick_q),
    .clk_internal_q  (clk_internal_q),
    .reset_pin_out_q (reset_pin_out_q),
    .reset_pin_oe_q  (reset_pin_oe_q),
    .sys_reset_q     (sys_reset_q),
    .reset_cause_q   (reset_cause_q),
    .bgnd_mode_q     (bgnd_mode_q),
    .dms_out_q       (dms_out_q),
    .dms_oe_q        (dms_oe_q)
);

/* File: test/ctrms_devsys.sv */
// development system model on the reset and debug pins
`timescale 1ns/10ps
module ctrms_devsys (
    input  wire hold_reset,
    input  wire hold_mode,
    input  wire reset_pin_oe_q,
    input  wire dms_out_q,
    input  wire dms_oe_q,
    output wire reset_pin_in,
    output wire debug_mode_select_pin_in
);
    // pull-up on the reset pin, either party may pull it low
    assign reset_pin_in = !(hold_reset || reset_pin_oe_q);
    // pull-up when idle; tool holding low wins, target speedup drives high
    assign debug_mode_select_pin_in = hold_mode ? 1'b0
                                    : (dms_oe_q ? dms_out_q : 1'b1);
endmodule

/* File: test/clock_tree_reset_mode_select_tb.sv */
// self-checking bench for the clock tree, reset pin and mode select block
`timescale 1ns/10ps
module clock_tree_reset_mode_select_tb;
    reg        clk_sys = 1'b0, rstn = 1'b0, dbg_tx_low = 1'b0;
    reg        low_power_1khz_clock = 1'b0, external_reference_clock = 1'b0;
    reg        internal_reference_clock = 1'b0, fixed_frequency_clock = 1'b0;
    reg        debug_speedup_clock = 1'b0, timer_a_external_clock_pin = 1'b0;
    reg        timer_b_external_clock_pin = 1'b0, osc_sel_external = 1'b0;
    reg        wdog_sel_slow = 1'b0, adc_sel_alt = 1'b0, can_sel_alt = 1'b0;
    reg        dbg_sel_speedup = 1'b0, hold_reset = 1'b0, hold_mode = 1'b0;
    reg  [1:0] rtc_sel = 2'h0, timer_a_sel = 2'h0, timer_b_sel = 2'h0;
    reg  [4:0] evt = 5'h00;
    wire       reset_pin_in, debug_mode_select_pin_in, bus_tick_q, wdog_tick_q;
    wire       rtc_tick_q, timer_a_tick_q, timer_b_tick_q, adc_alt_tick_q;
    wire       can_alt_tick_q, dbg_tick_q, dbg_bit_tick_q, clk_internal_q;
    wire       reset_pin_out_q, reset_pin_oe_q, sys_reset_q, bgnd_mode_q;
    wire       dbg_rx_q, dms_out_q, dms_oe_q;
    wire [7:0] reset_cause_q;
    wire [8:0] tk = {dbg_bit_tick_q, dbg_tick_q, can_alt_tick_q, adc_alt_tick_q,
                     timer_b_tick_q, timer_a_tick_q, rtc_tick_q, wdog_tick_q, bus_tick_q};
    integer    miscompares = 0, checks_done = 0, k;
    // source rates well apart so a wrong selection shows in the counts
    always #80 low_power_1khz_clock = !low_power_1khz_clock;
    always #40 external_reference_clock = !external_reference_clock;
    always #60 internal_reference_clock = !internal_reference_clock;
    always #20 fixed_frequency_clock = !fixed_frequency_clock;
    always #50 debug_speedup_clock = !debug_speedup_clock;
    always #100 timer_a_external_clock_pin = !timer_a_external_clock_pin;
    always #120 timer_b_external_clock_pin = !timer_b_external_clock_pin;
    initial begin
        forever #2.5 clk_sys = !clk_sys;
    end
    ctrms_core DUT (
        .clk_sys                    (clk_sys),
        .rstn                       (rstn),
        .low_power_1khz_clock       (low_power_1khz_clock),
        .external_reference_clock   (external_reference_clock),
        .internal_reference_clock   (internal_reference_clock),
        .fixed_frequency_clock      (fixed_frequency_clock),
        .debug_speedup_clock        (debug_speedup_clock),
        .timer_a_external_clock_pin (timer_a_external_clock_pin),
        .timer_b_external_clock_pin (timer_b_external_clock_pin),
        .wdog_sel_slow              (wdog_sel_slow),
        .rtc_sel                    (rtc_sel),
        .timer_a_sel                (timer_a_sel),
        .timer_b_sel                (timer_b_sel),
        .adc_sel_alt                (adc_sel_alt),
        .can_sel_alt                (can_sel_alt),
        .dbg_sel_speedup            (dbg_sel_speedup),
        .osc_sel_external           (osc_sel_external),
        .lvd_event                  (evt[0]),
        .wdog_event                 (evt[1]),
        .ilop_event                 (evt[2]),
        .ilad_event                 (evt[3]),
        .dbg_force_event            (evt[4]),
        .reset_pin_in               (reset_pin_in),
        .debug_mode_select_pin_in   (debug_mode_select_pin_in),
        .dbg_tx_low                 (dbg_tx_low),
        .bus_tick_q                 (bus_tick_q),
        .wdog_tick_q                (wdog_tick_q),
        .rtc_tick_q                 (rtc_tick_q),
        .timer_a_tick_q             (timer_a_tick_q),
        .timer_b_tick_q             (timer_b_tick_q),
        .adc_alt_tick_q             (adc_alt_tick_q),
        .can_alt_tick_q             (can_alt_tick_q),
        .dbg_tick_q                 (dbg_tick_q),
        .dbg_bit_tick_q             (dbg_bit_tick_q),
        .clk_internal_q             (clk_internal_q),
        .reset_pin_out_q            (reset_pin_out_q),
        .reset_pin_oe_q             (reset_pin_oe_q),
        .sys_reset_q                (sys_reset_q),
        .reset_cause_q              (reset_cause_q),
        .bgnd_mode_q                (bgnd_mode_q),
        .dbg_rx_q                   (dbg_rx_q),
        .dms_out_q                  (dms_out_q),
        .dms_oe_q                   (dms_oe_q)
    );
    ctrms_devsys u_devsys (
        .hold_reset               (hold_reset),
        .hold_mode                (hold_mode),
        .reset_pin_oe_q           (reset_pin_oe_q),
        .dms_out_q                (dms_out_q),
        .dms_oe_q                 (dms_oe_q),
        .reset_pin_in             (reset_pin_in),
        .debug_mode_select_pin_in (debug_mode_select_pin_in)
    );
    task close_out;
        begin
            if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task step(input integer n);
        begin
            repeat (n) @(posedge clk_sys);
            #1;
        end
    endtask
    task wait_rel;
        integer i;
        begin
            i = 0;
            while (sys_reset_q !== 1'b0 && i < 300) begin
                step(1);
                i = i + 1;
            end
            chk(sys_reset_q, 1'b0);
        end
    endtask
    // one internal reset; m holds the mode pin low across release
    task fire(input integer e, input m);
        integer n;
        begin
            hold_mode = m;
            evt = 5'h01 << e;
            step(1);
            evt = 5'h00;
            chk({reset_pin_oe_q, reset_cause_q}, {1'b1, 8'h02 << e});
            // internal reset follows the pin drive by one clock
            step(1);
            chk(sys_reset_q, 1'b1);
            n = 0;
            while (reset_pin_oe_q === 1'b1 && n < 100) begin
                step(1);
                n = n + 1;
            end
            chk(n >= 65 && n <= 69, 1'b1);
            wait_rel;
            step(4);
            chk({bgnd_mode_q, dbg_rx_q}, {m, !m});
            hold_mode = 1'b0;
            step(6);
            chk(bgnd_mode_q, m);
        end
    endtask
    // tick counts over 480 clocks; window edges give one tick of slack
    task rates(input [71:0] e);
        integer n, j, c [0:8];
        begin
            step(10);
            for (j = 0; j < 9; j = j + 1) c[j] = 0;
            for (n = 0; n < 480; n = n + 1) begin
                step(1);
                for (j = 0; j < 9; j = j + 1) c[j] = c[j] + tk[j];
            end
            for (j = 0; j < 9; j = j + 1)
                if (e[j*8+:8] != 8'hff)
                    chk((c[j] >= e[j*8+:8] - 1 && c[j] <= e[j*8+:8] + 1) ? e[j*8+:8] : c[j],
                        e[j*8+:8]);
        end
    endtask
    initial begin
        #200000;
        miscompares = miscompares + 1;
        close_out;
    end
    // power-on release, then a switch away from the internal clock
    task t_power_on;
        begin
            step(10);
            rstn = 1'b1;
            chk(reset_pin_oe_q, 1'b1);
            wait_rel;
            chk({reset_cause_q, bgnd_mode_q}, 9'h002);
            chk({clk_internal_q, dbg_rx_q}, 2'h3);
            osc_sel_external = 1'b1;
            step(4);
            chk(clk_internal_q, 1'b0);
            osc_sel_external = 1'b0;
        end
    endtask
    // reset pin held low from outside
    task t_pin_reset;
        begin
            hold_reset = 1'b1;
            step(6);
            chk({sys_reset_q, reset_cause_q}, 9'h140);
            hold_reset = 1'b0;
            wait_rel;
        end
    endtask
    // every selection against the rate of its source
    task t_rates;
        begin
            {wdog_sel_slow, adc_sel_alt, can_sel_alt, dbg_sel_speedup} = 4'hf;
            {rtc_sel, timer_a_sel, timer_b_sel} = 6'h05;
            rates({8'hff, 8'h18, 8'h1e, 8'h1e, 8'h3c,
                   8'h3c, 8'h0f, 8'h0f, 8'hf0});
            {wdog_sel_slow, adc_sel_alt, can_sel_alt, dbg_sel_speedup} = 4'h0;
            {rtc_sel, timer_a_sel, timer_b_sel} = 6'h1a;
            rates({8'h0f, 8'hf0, 8'hf0, 8'hf0, 8'h0a,
                   8'h0c, 8'h1e, 8'hf0, 8'hf0});
            rtc_sel = 2'h2;
            rates({8'h0f, 8'hf0, 8'hf0, 8'hf0, 8'h0a,
                   8'h0c, 8'h14, 8'hf0, 8'hf0});
            // unused counter code falls back to the slow clock, timers to bus rate
            {rtc_sel, timer_a_sel, timer_b_sel} = 6'h30;
            rates({8'h0f, 8'hf0, 8'hf0, 8'hf0, 8'hf0,
                   8'hf0, 8'h0f, 8'hf0, 8'hf0});
        end
    endtask
    // debug pin: driven low, speedup pulse, release
    task t_debug_pin;
        begin
            dbg_tx_low = 1'b1;
            step(3);
            chk({dms_oe_q, dms_out_q, debug_mode_select_pin_in}, 3'h4);
            dbg_tx_low = 1'b0;
            step(1);
            chk({dms_oe_q, dms_out_q}, 2'h3);
            step(2);
            chk(dms_oe_q, 1'b0);
        end
    endtask
    initial begin
        t_power_on;
        for (k = 0; k < 5; k = k + 1) fire(k, k == 1);
        chk(clk_internal_q, 1'b1);
        t_pin_reset;
        t_rates;
        t_debug_pin;
        close_out;
    end
endmodule
